//--- fabric_boot_pkg.sv
`default_nettype none
package fabric_boot_pkg;
  // ----------------------------------------
  // Identifiers
  // ----------------------------------------
  localparam logic [15:0] ID_BOOT_LONG = 16'h00FE;
  localparam logic [7:0] ID_BOOT_SHORT = 8'hFE;
  localparam logic [15:0] ID_UNSET_LONG = 16'hFFFF;
  localparam logic [7:0] ID_UNSET_SHORT = 8'hFF;
  localparam logic [15:0] ID_CPU_BASE = 16'h0000;
  localparam logic [7:0] HOP_ZERO = 8'h00;
  localparam logic [7:0] HOP_ONE = 8'h01;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [23:0] OFF_NODE_ID = 24'h000060;
  localparam logic [23:0] OFF_PORT_CTRL = 24'h00003C;
  localparam logic [23:0] OFF_ROUTE_BASE = 24'h000400;
  localparam int ROUTE_SEL_LSB = 10;
  localparam int ROUTE_IDX_LSB = 2;
  localparam int ROUTE_IDX_MSB = 9;
  localparam int PERMIT_BIT = 31;
  localparam int FOUND_BIT = 30;
  localparam logic [31:0] REG_ZERO = 32'h00000000;

  // ----------------------------------------
  // Packets and ports
  // ----------------------------------------
  localparam int PORT_W = 2;
  localparam logic [PORT_W-1:0] PORT_NONE = 2'h0;
  localparam int ROUTE_DEPTH = 256;

  typedef enum logic [2:0] {
    KIND_NREAD = 3'b000,
    KIND_NWRITE = 3'b001,
    KIND_MREAD = 3'b010,
    KIND_MWRITE = 3'b011,
    KIND_RESP = 3'b100,
    KIND_MRESP = 3'b101
  } kind_t;

  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_IDLE = 2'b01,
    ST_LOOK = 2'b10,
    ST_SEND = 2'b11
  } state_t;

  typedef enum logic [1:0] {
    ACT_ANSWER = 2'b00,
    ACT_FORWARD = 2'b01,
    ACT_ORIGIN = 2'b10
  } act_t;
endpackage
`default_nettype wire

//--- route_table.sv
`default_nettype none
module route_table
  import fabric_boot_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_idx,
  input wire logic [PORT_W-1:0] wr_port,
  input wire logic [7:0] rd_idx,
  output logic [PORT_W-1:0] rd_port_q
);
  logic [PORT_W-1:0] mem_q [ROUTE_DEPTH];
  logic [PORT_W-1:0] rd_port_d;

  always_comb begin
    rd_port_d = mem_q[rd_idx];
  end

  // Contents are not reset; an unwritten entry is masked by the caller
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_q[wr_idx] <= wr_port;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_port_q <= PORT_NONE;
    end else begin
      rd_port_q <= rd_port_d;
    end
  end
endmodule
`default_nettype wire

//--- fabric_boot_node.sv
// How it works
// R1: First processor fetch becomes fabric read, unconfigured.
// R2: Boot fetch targets identifier 0xFE / 0x00FE.
// R3: Processor identifiers sequential from zero.
// R4: Path nodes forward boot traffic from reset.
// R5: Default routes: boot id, processor id.
// R6: Maintenance answer leaves on arrival port.
// R7: Node identifier resets to all ones.
// R8: Permit bit reset clear agent, set host.
// R9: No origination without permit; still answer.
// R10: Switches forward freely, no permit bit.
// R11: Found flag reset clear agent, set host.
// R12: Answer maintenance to 0xFF at hop zero.
// R13: Switch by hop count; endpoint answers own.
// R14: Host assigns unique identifiers before permits.
// R15: Switch hop zero: answer from own registers.
// R16: Switch nonzero hop: decrement and route.
// R17: Match identifier register; writes apply next.
`default_nettype none
module fabric_boot_node
  import fabric_boot_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic role_host,
  input wire logic role_boot,
  input wire logic role_switch,
  input wire logic long_id,
  input wire logic [7:0] cpu_index,
  input wire logic [PORT_W-1:0] boot_port,
  input wire logic [PORT_W-1:0] host_port,
  input wire logic cpu_req_valid,
  input wire logic [31:0] cpu_req_addr,
  input wire logic [15:0] cpu_req_dest,
  output logic cpu_req_ack,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [PORT_W-1:0] rx_port,
  input wire logic [2:0] rx_kind,
  input wire logic [15:0] rx_dest,
  input wire logic [15:0] rx_src,
  input wire logic [7:0] rx_hop,
  input wire logic [31:0] rx_addr,
  input wire logic [31:0] rx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [PORT_W-1:0] tx_port,
  output logic [2:0] tx_kind,
  output logic [15:0] tx_dest,
  output logic [15:0] tx_src,
  output logic [7:0] tx_hop,
  output logic [31:0] tx_addr,
  output logic [31:0] tx_data,
  output logic local_valid,
  output logic [2:0] local_kind,
  output logic [31:0] local_addr,
  output logic [31:0] local_data,
  output logic [15:0] node_id,
  output logic issue_permit,
  output logic found
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic id_eq(input logic [15:0] a, input logic [15:0] b,
                                 input logic lng);
    id_eq = lng ? (a == b) : (a[7:0] == b[7:0]);
  endfunction

  function automatic logic is_route_off(input logic [31:0] a);
    is_route_off = a[23:ROUTE_SEL_LSB] == OFF_ROUTE_BASE[23:ROUTE_SEL_LSB];
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  state_t state_q, state_d;
  act_t act_q, act_d;
  logic sw_q, sw_d, lng_q, lng_d, boot_pend_q, boot_pend_d;
  logic [PORT_W-1:0] bport_q, bport_d, hport_q, hport_d, in_port_q, in_port_d;
  logic [15:0] id_q, id_d, txdst_d, txsrc_d;
  logic permit_q, permit_d, found_q, found_d;
  logic [ROUTE_DEPTH-1:0] prog_q, prog_d;
  logic [2:0] pk_kind_q, pk_kind_d, lk_d, txk_d;
  logic [15:0] pk_dest_q, pk_dest_d, pk_src_q, pk_src_d;
  logic [7:0] pk_hop_q, pk_hop_d, look_idx_q, look_idx_d, txh_d;
  logic [31:0] pk_addr_q, pk_addr_d, pk_data_q, pk_data_d;
  logic ack_d, rdy_d, lv_d, txv_d;
  logic [31:0] la_d, ld_d, txa_d, txdt_d, rd_val;
  logic [PORT_W-1:0] txp_d, mem_wport, mem_rport, route_sel;
  logic [7:0] mem_widx, mem_ridx;
  logic take, mine, maint, route_port_ok, mem_we;

  route_table u_route (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(mem_we),
    .wr_idx(mem_widx),
    .wr_port(mem_wport),
    .rd_idx(mem_ridx),
    .rd_port_q(mem_rport)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    act_d = act_q;
    {sw_d, lng_d, boot_pend_d} = {sw_q, lng_q, boot_pend_q};
    {bport_d, hport_d, in_port_d} = {bport_q, hport_q, in_port_q};
    {id_d, permit_d, found_d, prog_d} = {id_q, permit_q, found_q, prog_q};
    {pk_kind_d, pk_dest_d, pk_src_d} = {pk_kind_q, pk_dest_q, pk_src_q};
    {pk_hop_d, look_idx_d} = {pk_hop_q, look_idx_q};
    {pk_addr_d, pk_data_d} = {pk_addr_q, pk_data_q};
    {ack_d, lv_d} = 2'h0;
    {lk_d, la_d, ld_d} = {local_kind, local_addr, local_data};
    {txv_d, txp_d, txk_d} = {tx_valid, tx_port, tx_kind};
    {txdst_d, txsrc_d, txh_d} = {tx_dest, tx_src, tx_hop};
    {txa_d, txdt_d} = {tx_addr, tx_data};
    mem_we = 1'b0;
    mem_widx = rx_addr[ROUTE_IDX_MSB:ROUTE_IDX_LSB];
    mem_wport = rx_data[PORT_W-1:0];
    take = 1'b0;
    maint = (rx_kind == KIND_MREAD) || (rx_kind == KIND_MWRITE);
    mine = id_eq(rx_dest, id_q, lng_q);                         // R17
    route_port_ok = prog_q[look_idx_q];
    // Unprogrammed entries fall back to the boot and processor paths
    if (route_port_ok) begin
      route_sel = mem_rport;
    end else if (id_eq(pk_dest_q, ID_BOOT_LONG, lng_q)) begin
      route_sel = bport_q;                                      // R4 R5
    end else begin
      route_sel = hport_q;                                      // R5
    end
    rd_val = REG_ZERO;
    if (pk_addr_q[23:0] == OFF_NODE_ID) begin
      rd_val[15:0] = id_q;
    end else if (pk_addr_q[23:0] == OFF_PORT_CTRL) begin
      rd_val[PERMIT_BIT] = permit_q;
      rd_val[FOUND_BIT] = found_q;
    end else if (sw_q && is_route_off(pk_addr_q)) begin
      rd_val[PORT_W-1:0] = route_sel;
    end
    case (state_q)
      ST_INIT: begin
        // Straps are caught one edge after reset release
        sw_d = role_switch;
        lng_d = long_id;
        bport_d = boot_port;
        hport_d = host_port;
        boot_pend_d = !role_switch;
        if (role_host) begin
          id_d = ID_CPU_BASE + {8'h00, cpu_index};              // R3
        end else if (role_boot) begin
          id_d = long_id ? ID_BOOT_LONG : {8'h00, ID_BOOT_SHORT};
        end else begin
          id_d = long_id ? ID_UNSET_LONG : {8'h00, ID_UNSET_SHORT}; // R7
        end
        permit_d = role_host && !role_switch;                   // R8 R10
        found_d = role_host;                                    // R11
        state_d = ST_IDLE;
      end
      ST_IDLE: begin
        if (rx_valid && rx_ready) begin
          take = 1'b1;
          in_port_d = rx_port;
          pk_kind_d = rx_kind;
          pk_dest_d = rx_dest;
          pk_src_d = rx_src;
          pk_hop_d = rx_hop;
          pk_addr_d = rx_addr;
          pk_data_d = rx_data;
          look_idx_d = rx_dest[7:0];
          state_d = ST_LOOK;
          if (sw_q && maint && rx_hop == HOP_ZERO) begin
            act_d = ACT_ANSWER;                                 // R13 R15
            look_idx_d = rx_addr[ROUTE_IDX_MSB:ROUTE_IDX_LSB];
          end else if (sw_q && maint) begin
            act_d = ACT_FORWARD;                                // R16
            pk_hop_d = rx_hop - HOP_ONE;
          end else if (sw_q) begin
            act_d = ACT_FORWARD;                                // R4 R10
          end else if (maint && (mine ||
                       id_eq(rx_dest, ID_UNSET_LONG, lng_q))) begin
            act_d = ACT_ANSWER;                                 // R12 R13
          end else begin
            // Endpoint: own traffic goes to the local side
            lv_d = mine;
            lk_d = rx_kind;
            la_d = rx_addr;
            ld_d = rx_data;
            state_d = ST_IDLE;
          end
          if (act_d == ACT_ANSWER && rx_kind == KIND_MWRITE &&
              state_d == ST_LOOK) begin
            if (rx_addr[23:0] == OFF_NODE_ID) begin
              id_d = lng_q ? rx_data[15:0] : {8'h00, rx_data[7:0]}; // R17
            end else if (rx_addr[23:0] == OFF_PORT_CTRL) begin
              permit_d = rx_data[PERMIT_BIT] && !sw_q;          // R10
              found_d = rx_data[FOUND_BIT];                     // R11
            end else if (sw_q && is_route_off(rx_addr)) begin
              mem_we = 1'b1;
              prog_d[rx_addr[ROUTE_IDX_MSB:ROUTE_IDX_LSB]] = 1'b1;
            end
          end
        end else if (cpu_req_valid && !sw_q &&
                     (boot_pend_q || permit_q)) begin           // R1 R9
          ack_d = 1'b1;
          boot_pend_d = 1'b0;
          act_d = ACT_ORIGIN;
          pk_kind_d = KIND_NREAD;                               // R1
          pk_dest_d = boot_pend_q ? (lng_q ? ID_BOOT_LONG :
                      {8'h00, ID_BOOT_SHORT}) : cpu_req_dest;   // R2
          pk_src_d = id_q;
          pk_hop_d = HOP_ZERO;
          pk_addr_d = cpu_req_addr;
          pk_data_d = REG_ZERO;
          in_port_d = PORT_NONE;
          state_d = ST_LOOK;
        end
      end
      ST_LOOK: begin
        txv_d = 1'b1;
        txk_d = pk_kind_q;
        txdst_d = pk_dest_q;
        txsrc_d = pk_src_q;
        txh_d = pk_hop_q;
        txa_d = pk_addr_q;
        txdt_d = pk_data_q;
        txp_d = sw_q ? route_sel : PORT_NONE;
        if (act_q == ACT_ANSWER) begin
          txp_d = in_port_q;                                    // R6
          txk_d = KIND_MRESP;
          txdst_d = pk_src_q;
          txsrc_d = id_q;
          txh_d = HOP_ZERO;
          txdt_d = (pk_kind_q == KIND_MREAD) ? rd_val : REG_ZERO; // R15
        end
        state_d = ST_SEND;
      end
      ST_SEND: begin
        if (tx_ready) begin
          txv_d = 1'b0;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_INIT;
      end
    endcase
    // Next index, so the registered read is ready in the look-up cycle
    mem_ridx = look_idx_d;
    rdy_d = (state_d == ST_IDLE) && !take && !ack_d;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_INIT;
      act_q <= ACT_ANSWER;
      {sw_q, lng_q, boot_pend_q, permit_q, found_q} <= 5'h00;
      {bport_q, hport_q, in_port_q} <= {PORT_NONE, PORT_NONE, PORT_NONE};
      {id_q, pk_dest_q, pk_src_q} <= {3{ID_UNSET_LONG}};
      prog_q <= '0;
      pk_kind_q <= KIND_NREAD;
      {pk_hop_q, look_idx_q} <= {HOP_ZERO, ID_UNSET_SHORT};
      {pk_addr_q, pk_data_q} <= {REG_ZERO, REG_ZERO};
      {cpu_req_ack, rx_ready, local_valid, tx_valid} <= 4'h0;
      {local_kind, tx_kind} <= {KIND_NREAD, KIND_NREAD};
      {local_addr, local_data, tx_addr, tx_data} <= {4{REG_ZERO}};
      {tx_port, tx_hop} <= {PORT_NONE, HOP_ZERO};
      {tx_dest, tx_src, node_id} <= {3{ID_UNSET_LONG}};
      {issue_permit, found} <= 2'h0;
    end else begin
      state_q <= state_d;
      act_q <= act_d;
      {sw_q, lng_q, boot_pend_q} <= {sw_d, lng_d, boot_pend_d};
      {bport_q, hport_q, in_port_q} <= {bport_d, hport_d, in_port_d};
      {id_q, permit_q, found_q, prog_q} <= {id_d, permit_d, found_d, prog_d};
      {pk_kind_q, pk_dest_q, pk_src_q} <= {pk_kind_d, pk_dest_d, pk_src_d};
      {pk_hop_q, look_idx_q} <= {pk_hop_d, look_idx_d};
      {pk_addr_q, pk_data_q} <= {pk_addr_d, pk_data_d};
      {cpu_req_ack, rx_ready} <= {ack_d, rdy_d};
      {local_valid, local_kind} <= {lv_d, lk_d};
      {local_addr, local_data} <= {la_d, ld_d};
      {tx_valid, tx_port, tx_kind} <= {txv_d, txp_d, txk_d};
      {tx_dest, tx_src, tx_hop} <= {txdst_d, txsrc_d, txh_d};
      {tx_addr, tx_data} <= {txa_d, txdt_d};
      {node_id, issue_permit, found} <= {id_d, permit_d, found_d};
    end
  end
endmodule
`default_nettype wire

//--- fabric_boot_node_sva.sv
`default_nettype none
module fabric_boot_node_chk
  import fabric_boot_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic role_host,
  input wire logic role_boot,
  input wire logic role_switch,
  input wire logic long_id,
  input wire logic [7:0] cpu_index,
  input wire logic cpu_req_ack,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [PORT_W-1:0] rx_port,
  input wire logic [2:0] rx_kind,
  input wire logic [15:0] rx_dest,
  input wire logic [7:0] rx_hop,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [PORT_W-1:0] tx_port,
  input wire logic [2:0] tx_kind,
  input wire logic [15:0] tx_dest,
  input wire logic [7:0] tx_hop,
  input wire logic [15:0] node_id,
  input wire logic issue_permit,
  input wire logic found
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ----------------
  // Helper state
  // ----------------
  logic live_q, live_d, fetched_q, fetched_d;
  always_comb begin
    live_d = 1'b1;
    fetched_d = fetched_q | cpu_req_ack;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      live_q <= 1'b0;
      fetched_q <= 1'b0;
    end else begin
      live_q <= live_d;
      fetched_q <= fetched_d;
    end
  end
  // ----------------
  // Sequences
  // ----------------
  // Straps are latched on the first edge, so defaults show on the second
  sequence settled;
    live_q && !$past(live_q);
  endsequence
  sequence maint_in;
    rx_valid && rx_ready && rx_kind inside {KIND_MREAD, KIND_MWRITE};
  endsequence
  sequence first_fetch;
    cpu_req_ack && !fetched_q;
  endsequence
  // ----------------
  // Properties
  // ----------------
  chk_answer_port: assert property (
    maint_in ##0 (role_switch ? rx_hop == HOP_ZERO : (rx_dest == node_id
    || rx_dest == (long_id ? ID_UNSET_LONG : 16'(ID_UNSET_SHORT)))) |->
    ##2 tx_valid && tx_kind == KIND_MRESP && tx_port == $past(rx_port, 2))
    else $error("maintenance answer not on arrival port");
  chk_hop_step: assert property (
    maint_in ##0 (role_switch && rx_hop != HOP_ZERO) |->
    ##2 tx_valid && tx_hop == $past(rx_hop, 2) - HOP_ONE)
    else $error("forwarded hop count not decremented");
  chk_boot_fetch: assert property (
    first_fetch |=> tx_valid && tx_kind == KIND_NREAD
    && tx_dest == ID_BOOT_LONG)
    else $error("first fetch not aimed at boot node");
  chk_permit_gate: assert property (
    cpu_req_ack && fetched_q |-> $past(issue_permit))
    else $error("request issued without permit");
  chk_switch_quiet: assert property (
    role_switch && live_q |-> !issue_permit && !cpu_req_ack)
    else $error("switch shows permit or issues");
  chk_agent_id: assert property (
    settled ##0 (!role_host && !role_boot) |-> !issue_permit && !found
    && node_id == (long_id ? ID_UNSET_LONG : 16'(ID_UNSET_SHORT)))
    else $error("agent defaults wrong");
  chk_host_id: assert property (
    settled ##0 role_host |-> issue_permit && found
    && node_id == ID_CPU_BASE + 16'(cpu_index))
    else $error("host defaults wrong");
  chk_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_dest) && $stable(tx_port))
    else $error("outgoing packet changed while stalled");
endmodule

bind fabric_boot_node fabric_boot_node_chk fabric_boot_node_chk_inst (
  .clk_sys, .rst_n, .role_host, .role_boot, .role_switch, .long_id,
  .cpu_index, .cpu_req_ack, .rx_valid, .rx_ready, .rx_port, .rx_kind,
  .rx_dest, .rx_hop, .tx_valid, .tx_ready, .tx_port, .tx_kind, .tx_dest,
  .tx_hop, .node_id, .issue_permit, .found);
`default_nettype wire

//--- fabric_peer.sv
`default_nettype none
module fabric_peer
  import fabric_boot_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] stall,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [PORT_W-1:0] tx_port,
  input wire logic [2:0] tx_kind,
  input wire logic [15:0] tx_dest,
  input wire logic [7:0] tx_hop,
  input wire logic [31:0] tx_data,
  output logic [7:0] got_q,
  output logic [PORT_W-1:0] port_q,
  output logic [2:0] kind_q,
  output logic [15:0] dest_q,
  output logic [7:0] hop_q,
  output logic [31:0] data_q
);
  logic [3:0] wait_q;
  // A slow neighbour holds ready low for stall cycles of each packet
  assign tx_ready = tx_valid && wait_q >= stall;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 4'h0;
      got_q <= 8'h00;
    end else if (tx_ready) begin
      wait_q <= 4'h0;
      got_q <= got_q + 8'h01;
      {port_q, kind_q, dest_q, hop_q} <= {tx_port, tx_kind, tx_dest, tx_hop};
      data_q <= tx_data;
    end else if (tx_valid) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- fabric_boot_node_tb.sv
`default_nettype none
module fabric_boot_node_tb
  import fabric_boot_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0, rst_n = 1'b0, cpu_req_valid = 1'b0, rx_valid = 1'b0;
  logic role_host = 1'b0, role_boot = 1'b0, role_switch = 1'b0;
  logic long_id = 1'b0;
  logic [7:0] cpu_index = 8'h00, rx_hop = 8'h00;
  logic [1:0] boot_port = 2'h0, host_port = 2'h0, rx_port = 2'h0;
  logic [31:0] cpu_req_addr = 32'h0, rx_addr = 32'h0, rx_data = 32'h0;
  logic [15:0] cpu_req_dest = 16'h0, rx_dest = 16'h0, rx_src = 16'h0011;
  logic [2:0] rx_kind = 3'h0;
  logic [3:0] stall = 4'h0;
  logic cpu_req_ack, rx_ready, tx_valid, tx_ready, issue_permit, found, ok;
  logic local_valid;
  logic [1:0] tx_port, port_q;
  logic [2:0] tx_kind, kind_q, local_kind;
  logic [15:0] tx_dest, node_id, dest_q, tx_src;
  logic [7:0] tx_hop, got_q, hop_q, last;
  logic [31:0] tx_data, data_q, tx_addr, local_addr, local_data;
  int fail_count = 0, checked = 0;
  typedef struct packed {
    logic h, b, s, l;
    logic [7:0] i;
    logic [15:0] id;
    logic p, f;
  } row_t;
  row_t rows [5] = '{
    '{1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 16'h00FF, 1'b0, 1'b0},
    '{1'b0, 1'b0, 1'b1, 1'b1, 8'h00, 16'hFFFF, 1'b0, 1'b0},
    '{1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 16'h00FE, 1'b0, 1'b0},
    '{1'b0, 1'b1, 1'b0, 1'b1, 8'h00, 16'h00FE, 1'b0, 1'b0},
    '{1'b1, 1'b1, 1'b0, 1'b1, 8'h03, 16'h0003, 1'b1, 1'b1}};

  fabric_boot_node fabric_boot_node_inst (.clk_sys, .rst_n, .role_host,
    .role_boot, .role_switch, .long_id, .cpu_index, .boot_port, .host_port,
    .cpu_req_valid, .cpu_req_addr, .cpu_req_dest, .cpu_req_ack, .rx_valid,
    .rx_ready, .rx_port, .rx_kind, .rx_dest, .rx_src, .rx_hop, .rx_addr,
    .rx_data, .tx_valid, .tx_ready, .tx_port, .tx_kind, .tx_dest, .tx_src,
    .tx_hop, .tx_addr, .tx_data, .local_valid, .local_kind, .local_addr,
    .local_data, .node_id, .issue_permit, .found);
  fabric_peer fabric_peer_inst (.clk_sys, .rst_n, .stall, .tx_valid,
    .tx_ready, .tx_port, .tx_kind, .tx_dest, .tx_hop, .tx_data, .got_q,
    .port_q, .kind_q, .dest_q, .hop_q, .data_q);

  // ----------------
  // Tasks
  // ----------------
  task automatic test_done();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h got %h", n, e, g);
    end
  endtask
  task automatic do_reset(input logic h, b, s, l, input logic [7:0] i);
    rst_n = 1'b0;
    {role_host, role_boot, role_switch, long_id} = {h, b, s, l};
    cpu_index = i;
    repeat (2) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    last = 8'h00;
    @(posedge clk_sys) #1;
  endtask
  task automatic wait_tx();
    int n;
    for (n = 0; n < 40 && got_q === last; n++) @(posedge clk_sys) #1;
    chk("response", 32'(last + 8'h01), 32'(got_q));
    last = got_q;
  endtask
  task automatic quiet();
    repeat (15) @(posedge clk_sys);
    #1 chk("silence", 32'(last), 32'(got_q));
  endtask
  task automatic xfer(input logic [1:0] p, input logic [2:0] k,
    input logic [15:0] d, input logic [7:0] h, input logic [31:0] a, v);
    int n;
    {rx_port, rx_kind, rx_dest, rx_hop, rx_addr, rx_data} = {p, k, d, h, a, v};
    rx_valid = 1'b1;
    for (n = 0; n < 40 && rx_ready !== 1'b1; n++) @(posedge clk_sys) #1;
    @(posedge clk_sys) #1;
    rx_valid = 1'b0;
    // Released lines must not keep looking valid
    {rx_dest, rx_addr, rx_data} = ~{rx_dest, rx_addr, rx_data};
  endtask
  task automatic exp(input logic [1:0] p, input logic [2:0] k,
    input logic [15:0] d, input logic [7:0] h);
    wait_tx();
    chk("tx_port", 32'(p), 32'(port_q));
    chk("tx_kind", 32'(k), 32'(kind_q));
    chk("tx_dest", 32'(d), 32'(dest_q));
    chk("tx_hop", 32'(h), 32'(hop_q));
  endtask
  task automatic cpu(input logic [31:0] a, input logic [15:0] d,
    output logic got);
    int n;
    got = 1'b0;
    {cpu_req_addr, cpu_req_dest, cpu_req_valid} = {a, d, 1'b1};
    for (n = 0; n < 25 && got !== 1'b1; n++) begin
      @(posedge clk_sys) #1;
      got = cpu_req_ack;
    end
    if (got === 1'b1) begin
      @(posedge clk_sys) #1;
      cpu_req_valid = 1'b0;
      cpu_req_addr = ~a;
    end
  endtask

  // ----------------
  // Sequence
  // ----------------
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    #40000;
    fail_count++;
    $display("Error watchdog expected end got timeout");
    test_done();
  end
  initial begin
    foreach (rows[r]) begin
      do_reset(rows[r].h, rows[r].b, rows[r].s, rows[r].l, rows[r].i);
      chk("node_id", 32'(rows[r].id), 32'(node_id));
      chk("permit", 32'(rows[r].p), 32'(issue_permit));
      chk("found", 32'(rows[r].f), 32'(found));
    end
    do_reset(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    xfer(2'h2, KIND_MREAD, 16'h00FF, 8'h00, 32'h60, 32'h0);
    exp(2'h2, KIND_MRESP, 16'h0011, 8'h00);
    chk("id_read", 32'hFF, data_q);
    xfer(2'h1, KIND_MWRITE, 16'h00FF, 8'h00, 32'h60, 32'h5);
    exp(2'h1, KIND_MRESP, 16'h0011, 8'h00);
    xfer(2'h3, KIND_MREAD, 16'h0005, 8'h00, 32'h60, 32'h0);
    exp(2'h3, KIND_MRESP, 16'h0011, 8'h00);
    chk("id_read", 32'h5, data_q);
    chk("tx_src", 32'h5, 32'(tx_src));
    xfer(2'h0, KIND_MREAD, 16'h0007, 8'h00, 32'h60, 32'h0);
    chk("local_drop", 32'h0, 32'(local_valid));
    quiet();
    xfer(2'h0, KIND_NWRITE, 16'h0005, 8'h00, 32'h8, 32'h5A);
    chk("local_valid", 32'h1, 32'(local_valid));
    chk("local_kind", 32'(KIND_NWRITE), 32'(local_kind));
    chk("local_addr", 32'h8, local_addr);
    chk("local_data", 32'h5A, local_data);
    stall = 4'h3;
    cpu(32'h1000_0000, 16'h0033, ok);
    chk("fetch_ack", 32'h1, 32'(ok));
    exp(2'h0, KIND_NREAD, 16'h00FE, 8'h00);
    chk("tx_addr", 32'h1000_0000, tx_addr);
    cpu(32'h2000_0000, 16'h0033, ok);
    chk("gated_ack", 32'h0, 32'(ok));
    xfer(2'h1, KIND_MWRITE, 16'h0005, 8'h00, 32'h3C, 32'hC000_0000);
    exp(2'h1, KIND_MRESP, 16'h0011, 8'h00);
    cpu(32'h2000_0000, 16'h0033, ok);
    chk("permit_ack", 32'h1, 32'(ok));
    exp(2'h0, KIND_NREAD, 16'h0033, 8'h00);
    xfer(2'h1, KIND_MREAD, 16'h0005, 8'h00, 32'h3C, 32'h0);
    exp(2'h1, KIND_MRESP, 16'h0011, 8'h00);
    chk("ctrl_read", 32'hC000_0000, data_q);
    stall = 4'h0;
    {boot_port, host_port} = {2'h1, 2'h3};
    do_reset(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    xfer(2'h2, KIND_MREAD, 16'h0044, 8'h00, 32'h60, 32'h0);
    exp(2'h2, KIND_MRESP, 16'h0011, 8'h00);
    chk("sw_id", 32'hFF, data_q);
    xfer(2'h2, KIND_MREAD, 16'h00FE, 8'h01, 32'h60, 32'h0);
    exp(2'h1, KIND_MREAD, 16'h00FE, 8'h00);
    xfer(2'h0, KIND_MWRITE, 16'h00FF, 8'h00, 32'h510, 32'h2);
    exp(2'h0, KIND_MRESP, 16'h0011, 8'h00);
    xfer(2'h1, KIND_RESP, 16'h0000, 8'h00, 32'h0, 32'h9);
    exp(2'h3, KIND_RESP, 16'h0000, 8'h00);
    xfer(2'h3, KIND_NWRITE, 16'h0044, 8'h00, 32'h8, 32'hA5);
    exp(2'h2, KIND_NWRITE, 16'h0044, 8'h00);
    chk("fwd_data", 32'hA5, data_q);
    cpu(32'h1000_0000, 16'h0033, ok);
    chk("sw_ack", 32'h0, 32'(ok));
    quiet();
    test_done();
  end
endmodule
`default_nettype wire
